// File: common/csp_pkg.sv
// Constants, types and carriers for the codec serial port
// Assumes a word-addressed 32-bit Avalon-MM register bus
//
// What this block does
// - Phone mode routes alternate input in secondary frames
// - Conversion word shifted out with shift clock
// - Serial output released whenever frame sync idle
// - Function code latched at frame sync rise
// - Phone mode drives flags from control two
// - Frame sync held low every transfer bit
// - All link timing from master clock only
// - Monitor gain or mute from control two
// - Shift clock divided down from master clock
// - Power-down stops link, keeps register contents
package csp_pkg;
    // Register word indexes
    localparam logic [2:0] OFF_CTRL1  = 3'h0;
    localparam logic [2:0] OFF_CTRL2  = 3'h1;
    localparam logic [2:0] OFF_TXPRI  = 3'h2;
    localparam logic [2:0] OFF_TXSEC  = 3'h3;
    localparam logic [2:0] OFF_RXDATA = 3'h4;
    localparam logic [2:0] OFF_STATUS = 3'h5;
    // Control one fields
    localparam int unsigned C1_EN    = 0;
    localparam int unsigned C1_PHONE = 1;
    // Control two fields
    localparam int unsigned C2_FLAG_LO = 0;
    localparam int unsigned C2_FLAG_HI = 1;
    localparam int unsigned C2_MON_LO  = 2;
    localparam int unsigned C2_MON_HI  = 3;
    // Reset values
    localparam logic [1:0]  CTRL1_RST = 2'h0;
    localparam logic [3:0]  CTRL2_RST = 4'h0;
    localparam logic [15:0] WORD_RST  = 16'h0000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    // Link timing: half period in master clock cycles, gap and word in shift clock bits
    localparam logic [2:0] SCLK_HALF = 3'h4;
    localparam logic [4:0] GAP_BITS  = 5'h04;
    localparam logic [4:0] WORD_BITS = 5'h10;
    // Words sent from the register side
    typedef struct packed {
        logic [15:0] pri;
        logic [15:0] sec;
    } csp_tx_t;
    // Frame result sent back to the register side
    typedef struct packed {
        logic [15:0] data;
        logic        fc;
        logic        sec;
    } csp_rx_t;
    // Link sequencer states
    typedef enum logic [2:0] {
        L_IDLE  = 3'b001,
        L_GAP   = 3'b010,
        L_SHIFT = 3'b100
    } csp_lstate_t;
endpackage

// File: hw/csp_serial_port.sv
// Codec serial port: register slave plus master-clock link engine
// Assumes the host samples serial output on the shift clock fall
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module csp_serial_port
    import csp_pkg::*;
(
    input  wire logic        core_clk,        // Register clock
    input  wire logic        rstn,            // Async reset, low
    input  wire logic [2:0]  avs_address,     // Word index
    input  wire logic        avs_read,        // Read request
    input  wire logic        avs_write,       // Write request
    input  wire logic [31:0] avs_writedata,   // Write data
    output logic      [31:0] avs_readdata,    // Read data
    output logic             avs_waitrequest, // Stall
    input  wire logic        mclk,            // Master clock
    input  wire logic        alternateDataIn, // Alternate data pin
    input  wire logic        serialDataIn,    // Host data pin
    input  wire logic        functionCodePin, // Function code pin
    input  wire logic        powerDownPinN,   // Power-down, low
    output logic             shiftClock,      // Shift clock out
    output logic             frameSyncN,      // Frame sync, low
    output logic             serialDataOut,   // Data out value
    output logic             serialDataOe,    // Data out enable
    output logic      [1:0]  flagOut,         // Phone mode flags
    output logic      [1:0]  monitorOutput    // Monitor gain code
);

    // Address match shared by read and write
    function automatic logic regHit(input logic [2:0] a,
                                    input logic [2:0] off);
        regHit = (a == off);
    endfunction

    // ---------------- Register side ----------------
    logic        waitReq_q;   // Answer pending
    logic [31:0] readData_q;  // Read answer
    logic [1:0]  ctrl1_q;     // Enable and phone mode
    logic [3:0]  ctrl2_q;     // Flags and monitor gain
    csp_tx_t     txWord_q;    // Words to send
    logic        txTgl_q;     // New words event
    csp_rx_t     rxData_q;    // Last frame result
    logic [7:0]  rxCnt_q;     // Frames seen
    logic [2:0]  rxSync_q;    // Link event sync
    logic [1:0]  flag_q;      // Flag pins
    logic [1:0]  mon_q;       // Monitor code pins
    csp_rx_t     rxHold_q;    // Link frame result
    logic        rxTgl_q;     // Link frame-done toggle

    // Bus decode
    wire logic        rdTake  = avs_read & waitReq_q;
    wire logic        wrTake  = avs_write & ~waitReq_q;
    wire logic        wrC1    = wrTake & regHit(avs_address, OFF_CTRL1);
    wire logic        wrC2    = wrTake & regHit(avs_address, OFF_CTRL2);
    wire logic        wrPri   = wrTake & regHit(avs_address, OFF_TXPRI);
    wire logic        wrSec   = wrTake & regHit(avs_address, OFF_TXSEC);
    wire logic        rxEvent = rxSync_q[2] ^ rxSync_q[1];
    wire logic        phoneOn = ctrl1_q[C1_PHONE];
    wire logic [31:0] rdC1    = {30'h0000_0000, ctrl1_q};
    wire logic [31:0] rdC2    = {28'h000_0000, ctrl2_q};
    wire logic [31:0] rdPri   = {16'h0000, txWord_q.pri};
    wire logic [31:0] rdSec   = {16'h0000, txWord_q.sec};
    wire logic [31:0] rdRx    = {16'h0000, rxData_q.data};
    wire logic [31:0] rdSt    = {22'h00_0000, rxCnt_q,
                                 rxData_q.sec, rxData_q.fc};
    // Read select, unmapped reads zero
    wire logic [31:0] rdMux =
        regHit(avs_address, OFF_CTRL1)  ? rdC1 :
        regHit(avs_address, OFF_CTRL2)  ? rdC2 :
        regHit(avs_address, OFF_TXPRI)  ? rdPri :
        regHit(avs_address, OFF_TXSEC)  ? rdSec :
        regHit(avs_address, OFF_RXDATA) ? rdRx :
        regHit(avs_address, OFF_STATUS) ? rdSt : DATA_ZERO;

    // One wait cycle, then a single answer edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            waitReq_q <= 1'b1;
        end else begin
            waitReq_q <= ~((avs_read | avs_write) & waitReq_q);
        end
    end

    // Read data prepared as wait drops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            readData_q <= DATA_ZERO;
        end else if (rdTake) begin
            readData_q <= rdMux;
        end
    end

    // Control registers, kept across power-down
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl1_q <= CTRL1_RST;
            ctrl2_q <= CTRL2_RST;
        end else begin
            if (wrC1) begin
                ctrl1_q <= avs_writedata[1:0];
            end
            if (wrC2) begin
                ctrl2_q <= avs_writedata[3:0];
            end
        end
    end

    // Outgoing words and their change event
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txWord_q <= '{pri: WORD_RST, sec: WORD_RST};
            txTgl_q  <= 1'b0;
        end else begin
            if (wrPri) begin
                txWord_q.pri <= avs_writedata[15:0];
            end
            if (wrSec) begin
                txWord_q.sec <= avs_writedata[15:0];
            end
            txTgl_q <= txTgl_q ^ (wrPri | wrSec);
        end
    end

    // Frame-done toggle from the link, synchronised
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxSync_q <= 3'h0;
        end else begin
            rxSync_q <= {rxSync_q[1:0], rxTgl_q};
        end
    end

    // Frame result captured; link holds it a whole frame
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxData_q <= '{data: WORD_RST, fc: 1'b0, sec: 1'b0};
            rxCnt_q  <= 8'h00;
        end else if (rxEvent) begin
            rxData_q <= rxHold_q;
            rxCnt_q  <= rxCnt_q + 8'h01;
        end
    end

    // Flag and monitor pins
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 2'h0;
            mon_q  <= 2'h0;
        end else begin
            // Flags follow control two only in phone mode
            flag_q <= phoneOn ? ctrl2_q[C2_FLAG_HI:C2_FLAG_LO] : 2'h0;
            mon_q  <= ctrl2_q[C2_MON_HI:C2_MON_LO];
        end
    end

    assign avs_readdata    = readData_q;
    assign avs_waitrequest = waitReq_q;
    assign flagOut         = flag_q;
    assign monitorOutput   = mon_q;

    // ---------------- Link side, master clock ----------------
    localparam int unsigned SY_ALT = 0;
    localparam int unsigned SY_DIN = 1;
    localparam int unsigned SY_FC  = 2;
    localparam int unsigned SY_PWR = 3;
    localparam int unsigned SY_EN  = 4;
    localparam int unsigned SY_PH  = 5;
    localparam int unsigned SY_TX  = 6;

    logic [1:0]  lRst_q;    // Reset release sync
    logic [6:0]  sy1_q;     // First sync stage
    logic [6:0]  sy2_q;     // Second sync stage
    logic        txPrev_q;  // Last seen tx toggle
    csp_tx_t     txHold_q;  // Link copy of words
    csp_lstate_t state_q;   // Sequencer state
    csp_lstate_t state_d;   // Next state
    logic [2:0]  divCnt_q;  // Half-period counter
    logic        sclk_q;    // Shift clock
    logic [4:0]  bitCnt_q;  // Gap or bit counter
    logic        fs_q;      // Frame sync, low active
    logic        dout_q;    // Output bit
    logic        oe_q;      // Output enable
    logic [15:0] txSh_q;    // Output shifter
    logic [15:0] rxSh_q;    // Input shifter
    logic        sec_q;     // Current frame secondary

    // Link reset: async assert, release on master clock
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lRst_q <= 2'h0;
        end else begin
            lRst_q <= {lRst_q[0], 1'b1};
        end
    end
    wire logic lRstn = lRst_q[1];

    // Pins and control levels through two flops
    wire logic [6:0] syIn = {txTgl_q, phoneOn, ctrl1_q[C1_EN],
                             powerDownPinN, functionCodePin,
                             serialDataIn, alternateDataIn};
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            sy1_q <= 7'h00;
            sy2_q <= 7'h00;
        end else begin
            sy1_q <= syIn;
            sy2_q <= sy1_q;
        end
    end

    // Link decode
    wire logic run      = sy2_q[SY_EN] & sy2_q[SY_PWR];
    wire logic phoneL   = sy2_q[SY_PH];
    wire logic txNew    = sy2_q[SY_TX] ^ txPrev_q;
    wire logic divWrap  = (divCnt_q == SCLK_HALF - 3'h1);
    wire logic riseEv   = divWrap & ~sclk_q;
    wire logic fallEv   = divWrap & sclk_q;
    wire logic inGap    = (state_q == L_GAP);
    wire logic inShift  = (state_q == L_SHIFT);
    wire logic gapDone  = inGap & riseEv & (bitCnt_q == GAP_BITS - 5'h01);
    wire logic lastBit  = inShift & riseEv & (bitCnt_q == WORD_BITS - 5'h01);
    wire logic passAlt  = inShift & sec_q & phoneL;
    wire logic [15:0] loadWord = sec_q ? txHold_q.sec : txHold_q.pri;

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            L_IDLE: begin
                state_d = run ? L_GAP : L_IDLE;
            end
            L_GAP: begin
                state_d = !run ? L_IDLE : (gapDone ? L_SHIFT : L_GAP);
            end
            L_SHIFT: begin
                state_d = !run ? L_IDLE : (lastBit ? L_GAP : L_SHIFT);
            end
            default: begin
                state_d = L_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            state_q <= L_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Shift clock divided from master clock, low when idle or stopped
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            divCnt_q <= 3'h0;
            sclk_q   <= 1'b0;
        end else if (state_q == L_IDLE || !run) begin
            // Drops with frame sync so a cut frame never ends mid-high
            divCnt_q <= 3'h0;
            sclk_q   <= 1'b0;
        end else begin
            divCnt_q <= divWrap ? 3'h0 : divCnt_q + 3'h1;
            sclk_q   <= sclk_q ^ divWrap;
        end
    end

    // Gap and bit counter
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            bitCnt_q <= 5'h00;
        end else if (!run || gapDone || lastBit) begin
            bitCnt_q <= 5'h00;
        end else if (riseEv) begin
            bitCnt_q <= bitCnt_q + 5'h01;
        end
    end

    // Frame sync and output enable track the frame
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            fs_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (!run || lastBit) begin
            fs_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (gapDone) begin
            fs_q <= 1'b0;
            oe_q <= 1'b1;
        end
    end

    // Output bits on shift clock rise; in phone secondary frames the alternate input on every master clock
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            txSh_q <= WORD_RST;
            dout_q <= 1'b0;
        end else if (gapDone) begin
            txSh_q <= {loadWord[14:0], 1'b0};
            dout_q <= loadWord[15];
        end else if (passAlt) begin
            dout_q <= sy2_q[SY_ALT];
        end else if (inShift && riseEv && !lastBit) begin
            txSh_q <= {txSh_q[14:0], 1'b0};
            dout_q <= txSh_q[15];
        end
    end

    // Input bits on shift clock fall
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            rxSh_q <= WORD_RST;
        end else if (inShift && fallEv) begin
            rxSh_q <= {rxSh_q[14:0], sy2_q[SY_DIN]};
        end
    end

    // Frame end: result out, function code decides next kind after a primary, secondary always followed by primary
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            rxHold_q <= '{data: WORD_RST, fc: 1'b0, sec: 1'b0};
            rxTgl_q  <= 1'b0;
            sec_q    <= 1'b0;
        end else if (!run) begin
            sec_q <= 1'b0;
        end else if (lastBit) begin
            rxHold_q.data <= rxSh_q;
            rxHold_q.fc   <= sec_q ? 1'b0 : sy2_q[SY_FC];
            rxHold_q.sec  <= sec_q;
            rxTgl_q       <= ~rxTgl_q;
            sec_q         <= ~sec_q & sy2_q[SY_FC];
        end
    end

    // Word copy on a new-words event
    always_ff @(posedge mclk or negedge lRstn) begin
        if (!lRstn) begin
            txPrev_q <= 1'b0;
            txHold_q <= '{pri: WORD_RST, sec: WORD_RST};
        end else begin
            txPrev_q <= sy2_q[SY_TX];
            if (txNew) begin
                txHold_q <= txWord_q;
            end
        end
    end

    assign shiftClock    = sclk_q;
    assign frameSyncN    = fs_q;
    assign serialDataOut = dout_q;
    assign serialDataOe  = oe_q;

endmodule

// File: sim/csp_serial_port_asserts.sv
// Checker for the codec serial port pins and register bus
// Assumes it is bound to csp_serial_port and sees only its ports
`timescale 1ns/1ps
module csp_serial_port_asserts (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       mclk,
    input wire logic       shiftClock,
    input wire logic       frameSyncN,
    input wire logic       serialDataOe,
    input wire logic [1:0] flagOut,
    input wire logic [1:0] monitorOutput
);
    logic [7:0] fsCnt_q; // Master clocks spent inside the frame
    logic [2:0] wrDly_q; // Recent finished writes
    // Frame length counter
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fsCnt_q <= 8'h00;
        end else begin
            fsCnt_q <= frameSyncN ? 8'h00 : fsCnt_q + 8'h01;
        end
    end
    // Write history for output changes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrDly_q <= 3'h0;
        end else begin
            wrDly_q <= {wrDly_q[1:0], avs_write && !avs_waitrequest};
        end
    end
    a_oe_frame: assert property (@(posedge mclk) disable iff (!rstn) serialDataOe == !frameSyncN)
        else $error("data enable differs from frame");
    a_fs_start: assert property (@(posedge mclk) disable iff (!rstn) $fell(frameSyncN) |-> $rose(shiftClock))
        else $error("frame opened off a shift clock rise");
    a_fs_end: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(frameSyncN) |-> $rose(shiftClock) || !shiftClock)
        else $error("frame closed mid shift clock high");
    a_fs_bound: assert property (@(posedge mclk) disable iff (!rstn) !frameSyncN |-> fsCnt_q < 8'h80)
        else $error("frame longer than sixteen bits");
    a_sclk_high: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(shiftClock) && !frameSyncN |-> $past(shiftClock, 4) && !$past(shiftClock, 5))
        else $error("shift clock high phase not four master clocks");
    a_bus_answer: assert property (@(posedge core_clk) disable iff (!rstn)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait");
    a_wait_single: assert property (@(posedge core_clk) disable iff (!rstn) !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_cause: assert property (@(posedge core_clk) disable iff (!rstn)
        !avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    a_flag_cause: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(flagOut) || $changed(monitorOutput) |-> |wrDly_q)
        else $error("flag or monitor changed without a write");
endmodule
bind csp_serial_port csp_serial_port_asserts u_chk (.core_clk(core_clk), .rstn(rstn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mclk(mclk), .shiftClock(shiftClock),
    .frameSyncN(frameSyncN), .serialDataOe(serialDataOe), .flagOut(flagOut), .monitorOutput(monitorOutput));

// File: sim/csp_host_model.sv
// Host DSP side of the serial link
// Assumes shift clock idles low and frame sync is active low
`timescale 1ns/1ps
module csp_host_model (
    input  wire logic        shiftClock,
    input  wire logic        frameSyncN,
    input  wire logic        serialDataOut,
    input  wire logic        serialDataOe,
    input  wire logic [15:0] txWord,
    output logic             serialDataIn,
    output logic      [15:0] rxWord,
    output int               frames
);
    int          bitCnt;  // Bits taken in this frame
    logic [15:0] shReg;   // Incoming word
    logic        lineBit; // Level on the data wire
    // Released wire shows the inverse of the last driven bit
    assign lineBit = serialDataOe ? serialDataOut : ~serialDataOut;
    initial begin
        serialDataIn = 1'b0;
        rxWord = 16'h0000;
        frames = 0;
        bitCnt = 0;
        shReg = 16'h0000;
    end
    // Next bit after each rise, MSB first; toggles outside the word
    always @(posedge shiftClock) begin
        serialDataIn <= (!frameSyncN && bitCnt < 16) ? txWord[15 - bitCnt] : ~serialDataIn;
    end
    // Take device bits on the fall
    always @(negedge shiftClock) begin
        if (frameSyncN) begin
            bitCnt <= 0;
        end else begin
            shReg <= {shReg[14:0], lineBit};
            bitCnt <= bitCnt + 1;
            if (bitCnt == 15) begin
                rxWord <= {shReg[14:0], lineBit};
                frames <= frames + 1;
            end
        end
    end
endmodule

// File: sim/csp_serial_port_bench.sv
// Testbench for the codec serial port
// Assumes the host model and the bound checker beside the design
`timescale 1ns/1ps
module csp_serial_port_bench
    import csp_pkg::*;
;
    logic        core_clk, mclk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        alternateDataIn, serialDataIn, functionCodePin, powerDownPinN;
    logic        shiftClock, frameSyncN, serialDataOut, serialDataOe;
    logic [1:0]  flagOut, monitorOutput;
    logic [15:0] hostTx, hostRx;
    int          hostFrames, error_cnt, tests_run, cycles;
    csp_serial_port u_dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mclk(mclk), .alternateDataIn(alternateDataIn),
        .serialDataIn(serialDataIn), .functionCodePin(functionCodePin), .powerDownPinN(powerDownPinN),
        .shiftClock(shiftClock), .frameSyncN(frameSyncN), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .flagOut(flagOut), .monitorOutput(monitorOutput));
    csp_host_model u_host (.shiftClock(shiftClock), .frameSyncN(frameSyncN), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .txWord(hostTx), .serialDataIn(serialDataIn), .rxWord(hostRx),
        .frames(hostFrames));
    // Clocks, unrelated in phase
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        mclk = 1'b0;
        #3.3;
        forever #7.5 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask
    task automatic rdChk(input logic [2:0] a, input logic [15:0] exp);
        logic [31:0] q;
        bus(1'b1, a, DATA_ZERO, q);
        chk(q[15:0], exp);
    endtask
    task automatic waitFrames(input int n);
        int start;
        start = hostFrames;
        repeat (2000) begin
            @(posedge core_clk);
            if (hostFrames == start + n) break;
        end
        if (hostFrames != start + n) begin
            error_cnt++;
            $display("wrong value at %0t got %h expected %h", $time, hostFrames - start, n);
        end
        repeat (6) @(posedge core_clk);
    endtask
    // Two consecutive frames must be one primary and one secondary
    task automatic secPair(input logic [15:0] s);
        logic [15:0] a;
        waitFrames(1);
        waitFrames(1);
        a = hostRx;
        waitFrames(1);
        tests_run++;
        if (!((a === 16'hA5C3 && hostRx === s) || (a === s && hostRx === 16'hA5C3))) begin
            error_cnt++;
            $display("wrong value at %0t got %h expected %h", $time, {a, hostRx}, s);
        end
    endtask
    task automatic tRegs();
        rdChk(OFF_CTRL1, 16'h0000);
        rdChk(OFF_CTRL2, 16'h0000);
        wr(OFF_CTRL2, 32'hFFFF_FFFF);
        rdChk(OFF_CTRL2, 16'h000F);
        chk(16'(monitorOutput), 16'h0003);
        chk(16'(flagOut), 16'h0000);
        wr(3'h7, 32'h0000_5555);
        rdChk(3'h7, 16'h0000);
        wr(OFF_RXDATA, 32'h0000_5555);
        rdChk(OFF_RXDATA, 16'h0000);
    endtask
    task automatic tPrimary();
        hostTx <= 16'h3C5A;
        wr(OFF_TXPRI, 32'h0000_A5C3);
        wr(OFF_TXSEC, 32'h0000_1234);
        wr(OFF_CTRL1, 32'h0000_0001);
        waitFrames(2);
        chk(hostRx, 16'hA5C3);
        rdChk(OFF_RXDATA, 16'h3C5A);
        rdChk(OFF_STATUS, 16'h0008);
    endtask
    task automatic tSecondary();
        alternateDataIn <= 1'b1;
        functionCodePin <= 1'b1;
        secPair(16'h1234);
        functionCodePin <= 1'b0;
        waitFrames(2);
        chk(hostRx, 16'hA5C3);
    endtask
    task automatic tPhone();
        wr(OFF_CTRL2, 32'h0000_0006);
        wr(OFF_CTRL1, 32'h0000_0003);
        repeat (4) @(posedge core_clk);
        chk(16'(flagOut), 16'h0002);
        chk(16'(monitorOutput), 16'h0001);
        functionCodePin <= 1'b1;
        secPair(16'hFFFF);
        functionCodePin <= 1'b0;
        wr(OFF_CTRL1, 32'h0000_0001);
        repeat (4) @(posedge core_clk);
        chk(16'(flagOut), 16'h0000);
    endtask
    task automatic tPowerDown();
        repeat (200) begin
            @(posedge core_clk);
            if (frameSyncN === 1'b0) break;
        end
        powerDownPinN <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(16'({frameSyncN, serialDataOe, shiftClock}), 16'h0004);
        rdChk(OFF_CTRL2, 16'h0006);
        powerDownPinN <= 1'b1;
        waitFrames(2);
        chk(hostRx, 16'hA5C3);
    endtask
    initial begin
        rstn = 1'b0;
        avs_address = 3'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = DATA_ZERO;
        alternateDataIn = 1'b0;
        functionCodePin = 1'b0;
        powerDownPinN = 1'b1;
        hostTx = 16'h0000;
        error_cnt = 0;
        tests_run = 0;
        cycles = 0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        tRegs();
        tPrimary();
        tSecondary();
        tPhone();
        tPowerDown();
        complete_run();
    end
endmodule
